/* File: psf_framer.v */
// Purpose: Packet framer front end: preamble, sync word, payload from packet RAM and CRC on
//          transmit; sync word matching with bit error tolerance on receive.
// Assumes: One clock; AHB-Lite register port; received bits arrive with a valid strobe.
// Notes:   Transmit bits leave MSB first on a divided bit rate enable.
`include "psf_consts.vh"

module psf_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clock,
   input  wire             rst,
   input  wire             flush,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wp_r;
   reg [AW-1:0]    rp_r;
   reg [AW:0]      cnt_r;
   wire            push = in_valid & in_ready;
   wire            pop  = out_valid & out_ready;

   assign in_ready  = (cnt_r != DEPTH[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem[rp_r];

   always @(posedge clock) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else if (flush) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // psf_fifo

// Behaviour
// - Preamble lasts byte count times eight bits.
// - CRC polynomial joins low and high registers.
// - Sync match tolerates up to configured bit errors.
// - Sync length field gives bits, max 24.
// - Transmitted sync is always whole bytes.
// - Sync sent MSB first, upper toward lower.
// - Over 16 bits: upper, middle, lower sent.
// - Eight to sixteen bits: middle, lower sent.
// - One to seven bits: lower byte only.
// - Zero bits: no sync bytes sent.
// - First payload byte read at start pointer.
module psf_framer #(
   parameter BIT_DIV    = 20,
   parameter FIFO_DEPTH = 16
) (
   input  wire        clock,
   input  wire        rst,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   output reg         tx_bit,
   output reg         tx_bit_strobe,
   output wire        tx_active,
   input  wire        rx_bit,
   input  wire        rx_bit_valid,
   output reg         sync_detect
);
   localparam ST_IDLE = 5'b00001;
   localparam ST_PRE  = 5'b00010;
   localparam ST_SYNC = 5'b00100;
   localparam ST_DATA = 5'b01000;
   localparam ST_CRC  = 5'b10000;

   reg [7:0]  preamble_size_r;
   reg [7:0]  crc_low_r;
   reg [7:0]  crc_high_r;
   reg [7:0]  sync_config_r;
   reg [7:0]  sync_upper_r;
   reg [7:0]  sync_middle_r;
   reg [7:0]  sync_lower_r;
   reg [7:0]  tx_start_ptr_r;
   reg [7:0]  tx_length_r;
   reg        rx_en_r;
   reg        tx_done_r;
   reg        sync_seen_r;
   reg [7:0]  ram_addr_r;
   reg [7:0]  pkt_ram [0:255];

   reg        dp_act_r;
   reg        dp_write_r;
   reg        dp_wait_r;
   reg [9:0]  dp_idx_r;

   reg [4:0]  state_r;
   reg [7:0]  pre_left_r;
   reg [1:0]  sync_idx_r;
   reg [7:0]  len_left_r;
   reg [7:0]  fetch_ptr_r;
   reg [7:0]  fetch_left_r;
   reg [15:0] sh_r;
   reg [4:0]  bit_cnt_r;
   reg [15:0] crc_r;
   reg [7:0]  div_r;
   reg [23:0] rx_sh_r;

   wire [15:0] crc_generator_poly = {crc_high_r, crc_low_r};
   wire [4:0]  slen_raw = sync_config_r[`PSF_SLEN_HI:`PSF_SLEN_LO];
   wire [4:0]  slen     = (slen_raw > `PSF_SYNC_MAX_BITS) ? `PSF_SYNC_MAX_BITS : slen_raw;
   wire [1:0]  tol      = sync_config_r[`PSF_TOL_HI:`PSF_TOL_LO];
   wire [23:0] sync_pat = {sync_upper_r, sync_middle_r, sync_lower_r};
   wire        tick     = (div_r == 8'h00);
   wire        idle     = state_r[0];
   wire        dp_wr    = dp_act_r & dp_write_r;
   wire        start    = dp_wr & (dp_idx_r == `PSF_IDX_TX_CONTROL) &
                          hwdata[`PSF_CTRL_START] & idle;
   wire        ram_wr   = dp_wr & (dp_idx_r == `PSF_IDX_RAM_DATA);
   wire        ram_rd   = dp_act_r & ~dp_write_r & dp_wait_r &
                          (dp_idx_r == `PSF_IDX_RAM_DATA);
   wire        fifo_in_ready;
   wire [7:0]  fifo_out_data;
   wire        fifo_out_valid;
   wire        fifo_pop;
   wire        fetch_push = (fetch_left_r != 8'h00);
   wire [23:0] rx_sh_nxt  = {rx_sh_r[22:0], rx_bit};
   wire        sync_hit;

   // Number of whole sync bytes to send for a given matching length.
   function [1:0] sync_bytes;
      input [4:0] len;
      begin
         if (len >= `PSF_SYNC_THREE_MIN) begin
            sync_bytes = 2'h3;
         end else if (len >= `PSF_SYNC_TWO_MIN) begin
            sync_bytes = 2'h2;
         end else if (len != 5'h00) begin
            sync_bytes = 2'h1;
         end else begin
            sync_bytes = 2'h0;
         end
      end
   endfunction

   // Counts mismatching bits within the low len bits only.
   function [4:0] sync_errors;
      input [23:0] seen;
      input [23:0] pat;
      input [4:0]  len;
      integer      i;
      begin
         sync_errors = 5'h00;
         for (i = 0; i < 24; i = i + 1) begin
            if ((i < len) && (seen[i] != pat[i])) begin
               sync_errors = sync_errors + 5'h01;
            end
         end
      end
   endfunction

   assign sync_hit  = (slen != 5'h00) &&
                      (sync_errors(rx_sh_nxt, sync_pat, slen) <= {3'b000, tol});
   assign hreadyout = ~(dp_act_r & ~dp_write_r & ~dp_wait_r);
   assign hresp     = 1'b0;
   assign tx_active = ~idle;
   assign fifo_pop  = state_r[3] & (bit_cnt_r == 5'h00) &
                      (len_left_r != 8'h00) & fifo_out_valid;

   psf_fifo #(
      .WIDTH    (8),
      .DEPTH    (FIFO_DEPTH),
      .AW       (4)
   ) u_fifo (
      .clock    (clock),
      .rst      (rst),
      .flush    (start),
      .in_data  (pkt_ram[fetch_ptr_r]),
      .in_valid (fetch_push),
      .in_ready (fifo_in_ready),
      .out_data (fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop)
   );

   always @(posedge clock) begin
      if (ram_wr) begin
         pkt_ram[ram_addr_r] <= hwdata[7:0];
      end
   end

   // Bus slave: writes take no wait state, reads take one.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         dp_act_r   <= 1'b0;
         dp_write_r <= 1'b0;
         dp_wait_r  <= 1'b0;
         dp_idx_r   <= 10'h000;
         hrdata     <= 32'h00000000;
      end else begin
         if (hreadyout) begin
            dp_act_r   <= hsel & hready & htrans[1];
            dp_write_r <= hwrite;
            dp_idx_r   <= haddr[11:2];
            dp_wait_r  <= 1'b0;
         end else begin
            dp_wait_r <= 1'b1;
            hrdata    <= 32'h00000000;
            if (dp_idx_r == `PSF_IDX_PREAMBLE_SIZE) begin
               hrdata[7:0] <= preamble_size_r;
            end else if (dp_idx_r == `PSF_IDX_CRC_LOW) begin
               hrdata[7:0] <= crc_low_r;
            end else if (dp_idx_r == `PSF_IDX_CRC_HIGH) begin
               hrdata[7:0] <= crc_high_r;
            end else if (dp_idx_r == `PSF_IDX_SYNC_CONFIG) begin
               hrdata[7:0] <= sync_config_r;
            end else if (dp_idx_r == `PSF_IDX_SYNC_UPPER) begin
               hrdata[7:0] <= sync_upper_r;
            end else if (dp_idx_r == `PSF_IDX_SYNC_MIDDLE) begin
               hrdata[7:0] <= sync_middle_r;
            end else if (dp_idx_r == `PSF_IDX_SYNC_LOWER) begin
               hrdata[7:0] <= sync_lower_r;
            end else if (dp_idx_r == `PSF_IDX_TX_START_PTR) begin
               hrdata[7:0] <= tx_start_ptr_r;
            end else if (dp_idx_r == `PSF_IDX_TX_CONTROL) begin
               hrdata[`PSF_CTRL_RX_EN] <= rx_en_r;
            end else if (dp_idx_r == `PSF_IDX_TX_LENGTH) begin
               hrdata[7:0] <= tx_length_r;
            end else if (dp_idx_r == `PSF_IDX_STATUS) begin
               hrdata[`PSF_ST_BUSY]      <= ~idle;
               hrdata[`PSF_ST_TX_DONE]   <= tx_done_r;
               hrdata[`PSF_ST_SYNC_SEEN] <= sync_seen_r;
            end else if (dp_idx_r == `PSF_IDX_RAM_ADDR) begin
               hrdata[7:0] <= ram_addr_r;
            end else if (dp_idx_r == `PSF_IDX_RAM_DATA) begin
               hrdata[7:0] <= pkt_ram[ram_addr_r];
            end
         end
      end
   end

   // Register writes; status flags are cleared by writing one, and a new event wins.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         preamble_size_r <= `PSF_REG_RST;
         crc_low_r       <= `PSF_REG_RST;
         crc_high_r      <= `PSF_REG_RST;
         sync_config_r   <= `PSF_REG_RST;
         sync_upper_r    <= `PSF_REG_RST;
         sync_middle_r   <= `PSF_REG_RST;
         sync_lower_r    <= `PSF_REG_RST;
         tx_start_ptr_r  <= `PSF_REG_RST;
         tx_length_r     <= `PSF_REG_RST;
         ram_addr_r      <= `PSF_REG_RST;
         rx_en_r         <= 1'b0;
         tx_done_r       <= 1'b0;
         sync_seen_r     <= 1'b0;
      end else begin
         if (dp_wr) begin
            if (dp_idx_r == `PSF_IDX_PREAMBLE_SIZE) begin
               preamble_size_r <= hwdata[7:0];
            end else if (dp_idx_r == `PSF_IDX_CRC_LOW) begin
               crc_low_r <= hwdata[7:0];
            end else if (dp_idx_r == `PSF_IDX_CRC_HIGH) begin
               crc_high_r <= hwdata[7:0];
            end else if (dp_idx_r == `PSF_IDX_SYNC_CONFIG) begin
               sync_config_r <= hwdata[7:0];
            end else if (dp_idx_r == `PSF_IDX_SYNC_UPPER) begin
               sync_upper_r <= hwdata[7:0];
            end else if (dp_idx_r == `PSF_IDX_SYNC_MIDDLE) begin
               sync_middle_r <= hwdata[7:0];
            end else if (dp_idx_r == `PSF_IDX_SYNC_LOWER) begin
               sync_lower_r <= hwdata[7:0];
            end else if (dp_idx_r == `PSF_IDX_TX_START_PTR) begin
               tx_start_ptr_r <= hwdata[7:0];
            end else if (dp_idx_r == `PSF_IDX_TX_CONTROL) begin
               rx_en_r <= hwdata[`PSF_CTRL_RX_EN];
            end else if (dp_idx_r == `PSF_IDX_TX_LENGTH) begin
               tx_length_r <= hwdata[7:0];
            end else if (dp_idx_r == `PSF_IDX_RAM_ADDR) begin
               ram_addr_r <= hwdata[7:0];
            end
         end
         if (ram_wr | ram_rd) begin
            ram_addr_r <= ram_addr_r + 8'h01;
         end
         if (state_r[4] & (bit_cnt_r == 5'h00)) begin
            tx_done_r <= 1'b1;
         end else if (dp_wr & (dp_idx_r == `PSF_IDX_STATUS) & hwdata[`PSF_ST_TX_DONE]) begin
            tx_done_r <= 1'b0;
         end
         if (rx_en_r & rx_bit_valid & sync_hit) begin
            sync_seen_r <= 1'b1;
         end else if (dp_wr & (dp_idx_r == `PSF_IDX_STATUS) & hwdata[`PSF_ST_SYNC_SEEN]) begin
            sync_seen_r <= 1'b0;
         end
      end
   end

   // Receive side: sync detection pulse on the bit that completes a match.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_sh_r     <= 24'h000000;
         sync_detect <= 1'b0;
      end else begin
         sync_detect <= rx_en_r & rx_bit_valid & sync_hit;
         if (rx_bit_valid) begin
            rx_sh_r <= rx_sh_nxt;
         end
      end
   end

   // Packet RAM fetch into the FIFO, starting at the frame start pointer.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         fetch_ptr_r  <= 8'h00;
         fetch_left_r <= 8'h00;
      end else if (start) begin
         fetch_ptr_r  <= tx_start_ptr_r;
         fetch_left_r <= tx_length_r;
      end else if (fetch_push & fifo_in_ready) begin
         fetch_ptr_r  <= fetch_ptr_r + 8'h01;
         fetch_left_r <= fetch_left_r - 8'h01;
      end
   end

   // Transmit sequencer and serialiser; a unit is loaded between bit ticks.
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r       <= ST_IDLE;
         pre_left_r    <= 8'h00;
         sync_idx_r    <= `PSF_SYNC_NONE;
         len_left_r    <= 8'h00;
         sh_r          <= 16'h0000;
         bit_cnt_r     <= 5'h00;
         crc_r         <= `PSF_CRC_INIT;
         div_r         <= 8'h00;
         tx_bit        <= 1'b0;
         tx_bit_strobe <= 1'b0;
      end else begin
         tx_bit_strobe <= 1'b0;
         div_r <= (tick | idle) ? BIT_DIV[7:0] - 8'h01 : div_r - 8'h01;
         if (tick & ~idle & (bit_cnt_r != 5'h00)) begin
            tx_bit        <= sh_r[15];
            tx_bit_strobe <= 1'b1;
            sh_r          <= {sh_r[14:0], 1'b0};
            bit_cnt_r     <= bit_cnt_r - 5'h01;
            if (state_r[3]) begin
               crc_r <= {crc_r[14:0], 1'b0} ^ ((crc_r[15] ^ sh_r[15]) ? crc_generator_poly : 16'h0000);
            end
         end else if (bit_cnt_r == 5'h00) begin
            case (state_r)
               ST_IDLE: begin
                  if (start) begin
                     state_r    <= ST_PRE;
                     pre_left_r <= preamble_size_r;
                     sync_idx_r <= 2'h3 - sync_bytes(slen);
                     len_left_r <= tx_length_r;
                  end
               end
               ST_PRE: begin
                  if (pre_left_r != 8'h00) begin
                     sh_r       <= {`PSF_PREAMBLE_BYTE, 8'h00};
                     bit_cnt_r  <= `PSF_BYTE_BITS;
                     pre_left_r <= pre_left_r - 8'h01;
                  end else begin
                     state_r <= ST_SYNC;
                  end
               end
               ST_SYNC: begin
                  if (sync_idx_r == `PSF_SYNC_NONE) begin
                     state_r <= ST_DATA;
                     crc_r   <= `PSF_CRC_INIT;
                  end else begin
                     bit_cnt_r  <= `PSF_BYTE_BITS;
                     sync_idx_r <= sync_idx_r + 2'h1;
                     if (sync_idx_r == 2'h0) begin
                        sh_r <= {sync_upper_r, 8'h00};
                     end else if (sync_idx_r == 2'h1) begin
                        sh_r <= {sync_middle_r, 8'h00};
                     end else begin
                        sh_r <= {sync_lower_r, 8'h00};
                     end
                  end
               end
               ST_DATA: begin
                  if (len_left_r == 8'h00) begin
                     state_r   <= ST_CRC;
                     sh_r      <= crc_r;
                     bit_cnt_r <= `PSF_CRC_BITS;
                  end else if (fifo_out_valid) begin
                     sh_r       <= {fifo_out_data, 8'h00};
                     bit_cnt_r  <= `PSF_BYTE_BITS;
                     len_left_r <= len_left_r - 8'h01;
                  end
               end
               ST_CRC: begin
                  state_r <= ST_IDLE;
               end
               default: begin
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // psf_framer

/* File: psf_consts.vh */
// Purpose: Named constants of the packet framing front end.
// Assumes: Register indices; the byte address on the bus is four times the index.
// Notes:   Definitions only.
`ifndef PSF_CONSTS_VH
`define PSF_CONSTS_VH
`define PSF_IDX_PREAMBLE_SIZE  10'h11D
`define PSF_IDX_CRC_LOW        10'h11E
`define PSF_IDX_CRC_HIGH       10'h11F
`define PSF_IDX_SYNC_CONFIG    10'h120
`define PSF_IDX_SYNC_UPPER     10'h121
`define PSF_IDX_SYNC_MIDDLE    10'h122
`define PSF_IDX_SYNC_LOWER     10'h123
`define PSF_IDX_TX_START_PTR   10'h124
`define PSF_IDX_TX_CONTROL     10'h130
`define PSF_IDX_TX_LENGTH      10'h131
`define PSF_IDX_STATUS         10'h132
`define PSF_IDX_RAM_ADDR       10'h133
`define PSF_IDX_RAM_DATA       10'h134
`define PSF_CTRL_START         0
`define PSF_CTRL_RX_EN         1
`define PSF_ST_BUSY            0
`define PSF_ST_TX_DONE         1
`define PSF_ST_SYNC_SEEN       2
`define PSF_TOL_HI             7
`define PSF_TOL_LO             6
`define PSF_SLEN_HI            4
`define PSF_SLEN_LO            0
`define PSF_SYNC_MAX_BITS      5'h18
`define PSF_SYNC_TWO_MIN       5'h08
`define PSF_SYNC_THREE_MIN     5'h11
`define PSF_PREAMBLE_BYTE      8'hAA
`define PSF_CRC_INIT           16'hFFFF
`define PSF_REG_RST            8'h00
`define PSF_BYTE_BITS          5'h08
`define PSF_CRC_BITS           5'h10
`define PSF_SYNC_LAST          2'h2
`define PSF_SYNC_NONE          2'h3
`endif

/* File: psf_framer_sva.sv */
// Purpose: Assertions on the framer's bus, transmit and receive ports.
// Assumes: BIT_DIV of at least 2; hready is the framer's own hreadyout.
// Notes:   Bound to every psf_framer instance.
module psf_framer_sva #(
   parameter BIT_DIV    = 20,
   parameter FIFO_DEPTH = 16
) (
   input wire        clock,
   input wire        rst,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [2:0]  hsize,
   input wire        hready,
   input wire [31:0] hwdata,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire        tx_bit,
   input wire        tx_bit_strobe,
   input wire        tx_active,
   input wire        rx_bit,
   input wire        rx_bit_valid,
   input wire        sync_detect
);
   wire       go = hsel && hready && htrans[1] && hreadyout;
   reg [15:0] gap_r;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Cycles since the last transmit bit, saturating.
   always @(posedge clock or posedge rst) begin
      if (rst) gap_r <= 16'h0000;
      else if (tx_bit_strobe) gap_r <= 16'h0001;
      else if (gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
   end
   property p_rd_wait; go && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
   property p_wr_fast; go && hwrite |=> hreadyout; endproperty
   a_wr_fast: assert property (p_wr_fast) else $error("write was stalled");
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_rd_byte; hrdata[31:8] == 24'h000000; endproperty
   a_rd_byte: assert property (p_rd_byte) else $error("read data above bit 7");
   property p_bit_rate; tx_bit_strobe && gap_r != 16'h0000 |-> gap_r >= BIT_DIV; endproperty
   a_bit_rate: assert property (p_bit_rate) else $error("bits too close");
   property p_bit_frame; tx_bit_strobe |-> tx_active; endproperty
   a_bit_frame: assert property (p_bit_frame) else $error("bit outside frame");
   property p_first_bit; $rose(tx_active) |-> ##[1:80] tx_bit_strobe; endproperty
   a_first_bit: assert property (p_first_bit) else $error("frame sent no bit");
   property p_det_cause; sync_detect |-> $past(rx_bit_valid); endproperty
   a_det_cause: assert property (p_det_cause) else $error("detect without bit");
   property p_det_idle; !rx_bit_valid |=> !sync_detect; endproperty
   a_det_idle: assert property (p_det_idle) else $error("detect in idle cycle");
endmodule // psf_framer_sva

bind psf_framer psf_framer_sva #(.BIT_DIV(BIT_DIV), .FIFO_DEPTH(FIFO_DEPTH)) chk (
   .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe),
   .tx_active(tx_active), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
   .sync_detect(sync_detect));

/* File: psf_remote.sv */
// Purpose: Remote radio: records bits sent over the air and sends bits back.
// Assumes: Called just after a rising clock edge.
// Notes:   The idle data line shows the inverse of the last bit.
module psf_remote (
   input  wire  clock,
   input  wire  rst,
   input  wire  tx_bit,
   input  wire  tx_bit_strobe,
   output logic rx_bit,
   output logic rx_bit_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic bitq[$];
   initial begin
      rx_bit = 1'b0;
      rx_bit_valid = 1'b0;
   end
   always @(posedge clock) begin
      if (!rst && tx_bit_strobe) bitq.push_back(tx_bit);
   end
   // Returns right after the edge that takes the last bit.
   task send(input logic [23:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         rx_bit <= v[i];
         rx_bit_valid <= 1'b1;
         @(posedge clock);
         rx_bit <= ~v[i];
         rx_bit_valid <= 1'b0;
         if (i > 0) @(posedge clock);
      end
   endtask
endmodule // psf_remote

/* File: psf_framer_bench.sv */
// Purpose: Self-checking bench of the framer over its register bus and air link.
// Assumes: BIT_DIV of 2 keeps frames short.
// Notes:   Expected frames are built here from the configured registers.
`include "psf_consts.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module psf_framer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock, rst, hsel, hwrite;
   logic [31:0] haddr, hwdata, rv;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire  [31:0] hrdata;
   wire         hreadyout, hresp, tx_bit, tx_bit_strobe, tx_active;
   wire         rx_bit, rx_bit_valid, sync_detect;
   int          err_count, comparisons;
   logic        exq[$];
   logic [15:0] crc;
   psf_framer #(.BIT_DIV(2), .FIFO_DEPTH(16)) uut (
      .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_bit(tx_bit),
      .tx_bit_strobe(tx_bit_strobe), .tx_active(tx_active), .rx_bit(rx_bit),
      .rx_bit_valid(rx_bit_valid), .sync_detect(sync_detect));
   psf_remote rm (
      .clock(clock), .rst(rst), .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe),
      .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task conclude;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // One single transfer; hready is sampled just before each rising edge.
   task bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {20'h00000, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      do @(negedge clock); while (hreadyout !== 1'b1);
      @(posedge clock);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(negedge clock); while (hreadyout !== 1'b1);
      rv = hrdata;
      @(posedge clock);
   endtask
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) c = (c << 1) ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction
   task push(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) exq.push_back(v[i]);
   endtask
   task frame(input logic [4:0] len);
      exq.delete();
      rm.bitq.delete();
      push(16'h00AA, 8);
      push(16'h00AA, 8);
      if (len > 5'h10) push(16'h00D3, 8);
      if (len > 5'h07) push(16'h0091, 8);
      if (len > 5'h00) push(16'h005A, 8);
      push(16'h00C5, 8);
      push(16'h003C, 8);
      push(16'h0069, 8);
      crc = crc_byte(crc_byte(crc_byte(16'hFFFF, 8'hC5), 8'h3C), 8'h69);
      push(crc, 16);
      bus(1'b1, `PSF_IDX_SYNC_CONFIG, {3'h0, len});
      bus(1'b1, `PSF_IDX_TX_CONTROL, 8'h01);
      // A second start while busy must not restart or lengthen the frame.
      bus(1'b1, `PSF_IDX_TX_CONTROL, 8'h01);
      for (int k = 0; k < 3000 && tx_active !== 1'b0; k++) @(negedge clock);
      `CHK(tx_active, 1'b0);
      @(posedge clock);
      `CHK(rm.bitq.size(), exq.size());
      foreach (exq[i]) `CHK(rm.bitq[i], exq[i]);
   endtask
   task rx_try(input logic [1:0] tol, input int errs, input logic e);
      bus(1'b1, `PSF_IDX_SYNC_CONFIG, {tol, 6'h0C});
      rm.send(24'h00015A ^ ((24'h000001 << errs) - 24'h000001), 12);
      @(negedge clock);
      `CHK(sync_detect, e);
      @(posedge clock);
   endtask
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, `PSF_IDX_PREAMBLE_SIZE + i, 8'h00);
         `CHK(rv, 32'h00000000);
         bus(1'b1, `PSF_IDX_PREAMBLE_SIZE + i, 8'hA0 + i);
         bus(1'b0, `PSF_IDX_PREAMBLE_SIZE + i, 8'h00);
         `CHK(rv, 32'h000000A0 + i);
      end
      bus(1'b1, 10'h200, 8'hFF);
      bus(1'b0, 10'h200, 8'h00);
      `CHK(rv, 32'h00000000);
      bus(1'b1, `PSF_IDX_PREAMBLE_SIZE, 8'h02);
      bus(1'b1, `PSF_IDX_CRC_LOW, 8'h21);
      bus(1'b1, `PSF_IDX_CRC_HIGH, 8'h10);
      bus(1'b1, `PSF_IDX_SYNC_UPPER, 8'hD3);
      bus(1'b1, `PSF_IDX_SYNC_MIDDLE, 8'h91);
      bus(1'b1, `PSF_IDX_SYNC_LOWER, 8'h5A);
      bus(1'b1, `PSF_IDX_TX_START_PTR, 8'hFE);
      bus(1'b1, `PSF_IDX_TX_LENGTH, 8'h03);
      bus(1'b1, `PSF_IDX_RAM_ADDR, 8'hFE);
      bus(1'b1, `PSF_IDX_RAM_DATA, 8'hC5);
      bus(1'b1, `PSF_IDX_RAM_DATA, 8'h3C);
      bus(1'b1, `PSF_IDX_RAM_DATA, 8'h69);
      // Read the payload back through the auto-incrementing pointer, across the wrap.
      bus(1'b1, `PSF_IDX_RAM_ADDR, 8'hFE);
      bus(1'b0, `PSF_IDX_RAM_DATA, 8'h00);
      `CHK(rv, 32'h000000C5);
      bus(1'b0, `PSF_IDX_RAM_DATA, 8'h00);
      `CHK(rv, 32'h0000003C);
      bus(1'b0, `PSF_IDX_RAM_DATA, 8'h00);
      `CHK(rv, 32'h00000069);
      bus(1'b0, `PSF_IDX_RAM_ADDR, 8'h00);
      `CHK(rv, 32'h00000001);
      frame(5'h00);
      frame(5'h01);
      frame(5'h07);
      frame(5'h08);
      frame(5'h0F);
      frame(5'h11);
      frame(5'h18);
      frame(5'h1F);
      bus(1'b0, `PSF_IDX_STATUS, 8'h00);
      `CHK(rv[2:0], 3'h2);
      bus(1'b1, `PSF_IDX_TX_CONTROL, 8'h02);
      bus(1'b1, `PSF_IDX_STATUS, 8'h06);
      for (int t = 0; t < 4; t++) begin
         rx_try(t[1:0], t, 1'b1);
         rx_try(t[1:0], t + 1, 1'b0);
      end
      bus(1'b0, `PSF_IDX_STATUS, 8'h00);
      `CHK(rv[2:0], 3'h4);
      conclude();
   end
   initial begin
      repeat (40000) @(posedge clock);
      err_count++;
      conclude();
   end
endmodule // psf_framer_bench
